// ==== verilog/dcs_top.sv ====
/*
 * Drive control word sequencer: interprets cyclic and acyclic control
 * words and targets, runs positioning and manual runs, decodes the
 * address switches and drives the port and motor LEDs.
 * Assumes all inputs synchronous to i_clk_sys and an APB master.
 */
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps

module dcs_top
    import dcs_pkg::*;
#(
    parameter int unsigned FLICK_DIV =
        `DCS_CLK_HZ / (2 * `DCS_FLICK_HZ),
    parameter int unsigned POS_DIV   = `DCS_POS_DIV,
    parameter int unsigned MAN_DIV   = `DCS_MAN_DIV
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_pd_valid,
    input  wire logic [7:0]  i_pd_ctrl,
    input  wire logic [31:0] i_pd_target,
    input  wire logic [3:0]  i_addr_tens,
    input  wire logic [3:0]  i_addr_ones,
    output logic [6:0]       o_node_addr,
    input  wire logic [1:0]  i_link,
    input  wire logic [1:0]  i_act,
    output logic [1:0]       o_port_link_activity_leds,
    input  wire logic        i_vmot_low,
    input  wire logic        i_vmot_high,
    output logic             o_motor_led,
    output logic             o_step,
    output logic             o_dir,
    output logic             o_manual_speed,
    output logic             o_busy,
    output logic [31:0]      o_pos
);

    // ======================================================
    // Reset release through two flip-flops.
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // ======================================================
    // Rate enables: LED flicker toggle, fast and slow steps.
    logic flick_tick;
    logic pos_tick;
    logic man_tick;

    dcs_tick_div #(.DIV(FLICK_DIV)) u_flick (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n),
        .o_tick  (flick_tick)
    );

    dcs_tick_div #(.DIV(POS_DIV)) u_pos (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n),
        .o_tick  (pos_tick)
    );

    dcs_tick_div #(.DIV(MAN_DIV)) u_man (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n),
        .o_tick  (man_tick)
    );

    // ======================================================
    // State and bus decode.
    dcs_state_s s_q;
    dcs_state_s s_d;

    logic        preop;
    logic        oper;
    logic        acc;
    logic        wr;
    logic        mapped;
    logic        ro_hit;
    logic        lock_hit;
    logic [31:0] rd_mux;
    logic [31:0] tgt_ext;

    assign preop = (s_q.cyc == `DCS_CYC_PRE1) ||
                   (s_q.cyc == `DCS_CYC_PRE2);
    assign oper  = (s_q.cyc == `DCS_CYC_OP);
    assign acc   = i_psel && i_penable;
    assign wr    = acc && i_pwrite;
    assign tgt_ext = {s_q.tgt[30], s_q.tgt};

    assign mapped = (i_paddr == `DCS_A_CTRL) ||
                    (i_paddr == `DCS_A_TGT)  ||
                    (i_paddr == `DCS_A_LOOP) ||
                    (i_paddr == `DCS_A_STAT) ||
                    (i_paddr == `DCS_A_CYC)  ||
                    (i_paddr == `DCS_A_POS);
    assign ro_hit = (i_paddr == `DCS_A_STAT) ||
                    (i_paddr == `DCS_A_POS);
    // Acyclic control and target writes are refused outside
    // pre-operational, and the refusal shows as an error.
    assign lock_hit = !preop && ((i_paddr == `DCS_A_CTRL) ||
                                 (i_paddr == `DCS_A_TGT));

    // One wait-free access phase; read data was latched at setup.
    assign o_pready  = 1'b1;
    assign o_pslverr = acc && (!mapped ||
                       (i_pwrite && (ro_hit || lock_hit)));

    // Read multiplexer, sampled in the setup cycle.
    always_comb
    begin
        rd_mux = 32'h0;
        case (i_paddr)
            `DCS_A_CTRL: rd_mux = {24'h0, s_q.ctrl};
            `DCS_A_TGT:  rd_mux = tgt_ext;
            `DCS_A_LOOP: rd_mux = {{16{s_q.loop[15]}}, s_q.loop};
            `DCS_A_STAT:
            begin
                rd_mux[1:0]          = s_q.run;
                rd_mux[`DCS_ST_VIA]  = s_q.via_on;
                rd_mux[`DCS_ST_ARM]  = s_q.armed;
                rd_mux[`DCS_ST_MOT]  = s_q.mot;
                rd_mux[`DCS_ST_NODE +: 7] = s_q.node;
                rd_mux[`DCS_ST_NBAD] = (s_q.node == 7'h0);
            end
            `DCS_A_CYC:  rd_mux = {29'h0, s_q.cyc};
            `DCS_A_POS:  rd_mux = s_q.pos;
            default:     rd_mux = 32'h0;
        endcase
    end

    // ======================================================
    // Next state: LEDs, commands, motion and bus.
    always_comb
    begin
        logic        cmd;
        logic        tgt_evt;
        logic        apb_tgt;
        logic [7:0]  w;
        logic [31:0] nt;
        logic [31:0] aim;
        logic        start;
        logic        up;
        cmd     = 1'b0;
        tgt_evt = 1'b0;
        apb_tgt = 1'b0;
        w       = s_q.ctrl;
        nt      = tgt_ext;
        aim     = 32'h0;
        start   = 1'b0;
        up      = 1'b0;
        s_d      = s_q;
        s_d.step = 1'b0;

        // Address from the two decimal switches.
        s_d.node = 7'({4'h0, i_addr_tens} * 8'd10 +
                      {4'h0, i_addr_ones});
        // Motor LED follows the window comparator.
        s_d.mot = !i_vmot_low && !i_vmot_high;

        // Activity seen since the last toggle keeps the port
        // flickering; the 10 Hz blink is two toggles.
        if (flick_tick)
        begin
            s_d.blink = !s_q.blink;
            s_d.hold  = s_q.seen | i_act;
            s_d.seen  = 2'h0;
        end
        else
        begin
            s_d.seen = s_q.seen | i_act;
        end
        s_d.led = i_link & (~s_q.hold | {2{s_q.blink}});

        // Motion at the rate of the current run; the direction is
        // worked out live so a retarget never stops a run.
        if (s_q.run == DCS_POS && pos_tick)
        begin
            aim = s_q.via_on ? s_q.via : tgt_ext;
            if (s_q.pos == aim)
            begin
                if (s_q.via_on)
                    s_d.via_on = 1'b0;
                else
                    s_d.run = DCS_IDLE;
            end
            else
            begin
                s_d.dir  = $signed(aim) > $signed(s_q.pos);
                s_d.pos  = s_d.dir ? s_q.pos + 32'h1
                                   : s_q.pos - 32'h1;
                s_d.step = 1'b1;
            end
        end
        else if (s_q.run == DCS_MAN && man_tick)
        begin
            s_d.pos  = s_q.dir ? s_q.pos + 32'h1 : s_q.pos - 32'h1;
            s_d.step = 1'b1;
        end

        // Cyclic words count only when something changed, so a
        // repeated word does not restart a finished run.
        if (i_pd_valid && oper &&
            (i_pd_ctrl != s_q.ctrl ||
             (i_pd_ctrl[`DCS_CW_TGT] &&
              i_pd_target[30:0] != s_q.tgt)))
        begin
            cmd = 1'b1;
            w   = i_pd_ctrl;
            if (i_pd_ctrl[`DCS_CW_TGT])
            begin
                tgt_evt = 1'b1;
                nt      = {i_pd_target[30], i_pd_target[30:0]};
            end
        end
        else if (wr && !lock_hit && i_paddr == `DCS_A_CTRL)
        begin
            cmd = 1'b1;
            w   = i_pwdata[7:0];
        end
        else if (wr && !lock_hit && i_paddr == `DCS_A_TGT)
        begin
            apb_tgt = 1'b1;
            tgt_evt = 1'b1;
            nt      = {i_pwdata[30], i_pwdata[30:0]};
        end

        if (tgt_evt)
        begin
            s_d.tgt   = nt[30:0];
            s_d.armed = 1'b1;
        end

        if (cmd)
        begin
            s_d.ctrl = w;
            if (!w[`DCS_CW_REL])
            begin
                // Store only; any run stops.
                s_d.run    = DCS_IDLE;
                s_d.via_on = 1'b0;
            end
            else if (w[`DCS_CW_FWD] || w[`DCS_CW_REV])
            begin
                // Manual speed divider takes over from positioning.
                s_d.run    = DCS_MAN;
                s_d.via_on = 1'b0;
                s_d.dir    = w[`DCS_CW_FWD];
            end
            else if (w[`DCS_CW_TGT])
            begin
                start = 1'b1;
            end
            else if (s_q.run == DCS_MAN)
            begin
                s_d.run = DCS_IDLE;
            end
            else if (s_q.run == DCS_IDLE)
            begin
                start = s_q.armed || !s_q.ctrl[`DCS_CW_REL];
            end
        end
        else if (apb_tgt && s_q.ctrl[`DCS_CW_REL] &&
                 s_q.run != DCS_IDLE)
        begin
            start = 1'b1;
        end

        if (start)
        begin
            // A target ends a manual run and drops its bits.
            s_d.ctrl[`DCS_CW_REV:`DCS_CW_FWD] = 2'h0;
            s_d.run   = DCS_POS;
            s_d.armed = 1'b0;
            // Positive loop length finishes upward, negative
            // downward; zero runs straight in.
            up = $signed(nt) > $signed(s_q.pos);
            s_d.via_on = (s_q.loop != 16'h0) &&
                         (up == s_q.loop[15]);
            s_d.via = nt - {{16{s_q.loop[15]}}, s_q.loop};
        end

        // Registers without side effects.
        if (wr && i_paddr == `DCS_A_LOOP)
            s_d.loop = i_pwdata[15:0];
        if (wr && i_paddr == `DCS_A_CYC)
            s_d.cyc = i_pwdata[2:0];
        if (i_psel && !i_penable && !i_pwrite)
            s_d.prdata = rd_mux;
    end

    // Reset leaves the drive idle with the cycle state off, so no control word or target is taken until the cycle state is written.
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q      <= '0;
            s_q.ctrl <= `DCS_CW_RST;
            s_q.cyc  <= `DCS_CYC_OFF;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Outputs.
    assign o_prdata                  = s_q.prdata;
    assign o_node_addr               = s_q.node;
    assign o_port_link_activity_leds = s_q.led;
    assign o_motor_led               = s_q.mot;
    assign o_step                    = s_q.step;
    assign o_dir                     = s_q.dir;
    assign o_manual_speed            = (s_q.run == DCS_MAN);
    assign o_busy                    = (s_q.run != DCS_IDLE);
    assign o_pos                     = s_q.pos;

endmodule : dcs_top

// ==== verilog/dcs_consts.svh ====
/*
 * Offsets, field positions, reset values and timing figures of the
 * drive control word sequencer.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// ==========================================================
// Register byte offsets on the APB
`define DCS_A_CTRL   8'h00
`define DCS_A_TGT    8'h04
`define DCS_A_LOOP   8'h08
`define DCS_A_STAT   8'h0c
`define DCS_A_CYC    8'h10
`define DCS_A_POS    8'h14

// ==========================================================
// Control word fields and values
`define DCS_CW_REL   4
`define DCS_CW_TGT   2
`define DCS_CW_FWD   0
`define DCS_CW_REV   1
`define DCS_CW_RST   8'h00

// ==========================================================
// Cycle state codes
`define DCS_CYC_OFF  3'h0
`define DCS_CYC_PRE1 3'h2
`define DCS_CYC_PRE2 3'h3
`define DCS_CYC_OP   3'h5

// ==========================================================
// Status fields
`define DCS_ST_VIA   2
`define DCS_ST_ARM   3
`define DCS_ST_MOT   4
`define DCS_ST_NODE  8
`define DCS_ST_NBAD  15

// ==========================================================
// Timing
`define DCS_CLK_HZ     20000000
`define DCS_FLICK_HZ   10
`define DCS_POS_DIV    1000
`define DCS_MAN_DIV    4000

`endif

// ==== verilog/dcs_pkg.sv ====
/*
 * Types of the drive control word sequencer.
 * Assumes the constants header is on the include path.
 */
`include "dcs_consts.svh"

package dcs_pkg;

    // ======================================================
    // Run states
    typedef enum logic [1:0] {DCS_IDLE, DCS_POS, DCS_MAN} dcs_run_e;

    // ======================================================
    // Whole state of the sequencer
    typedef struct packed {
        dcs_run_e     run;
        logic [7:0]   ctrl;
        logic [30:0]  tgt;
        logic [31:0]  via;
        logic         via_on;
        logic         armed;
        logic [15:0]  loop;
        logic [2:0]   cyc;
        logic [31:0]  pos;
        logic [31:0]  prdata;
        logic [6:0]   node;
        logic [1:0]   led;
        logic [1:0]   seen;
        logic [1:0]   hold;
        logic         blink;
        logic         mot;
        logic         step;
        logic         dir;
    } dcs_state_s;

    // Whole state of a rate divider.
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } dcs_div_s;

endpackage : dcs_pkg

// ==== verilog/dcs_tick_div.sv ====
/*
 * Rate divider: one-cycle enable pulse every DIV clock cycles.
 * Assumes a synchronous active-low reset from the top.
 */
`timescale 1ns/1ps

module dcs_tick_div
    import dcs_pkg::*;
#(
    parameter int unsigned DIV = 1000
)(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    output logic      o_tick
);

    dcs_div_s s_q;
    dcs_div_s s_d;

    // ======================================================
    // Count down and pulse at wrap.
    always_comb
    begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 32'h0)
        begin
            s_d.cnt  = DIV - 1;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt - 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_tick = s_q.tick;

endmodule : dcs_tick_div

// ==== sim/dcs_props.sv ====
/* Port checker of the sequencer.
   Assumes binding to dcs_top and the constants header on the path. */
`timescale 1ns/1ps
`include "dcs_consts.svh"
// ====================================================
// Checker
module dcs_props
    import dcs_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic        o_pslverr,
    input wire logic        i_pd_valid,
    input wire logic [3:0]  i_addr_tens,
    input wire logic [3:0]  i_addr_ones,
    input wire logic [6:0]  o_node_addr,
    input wire logic [1:0]  i_link,
    input wire logic [1:0]  o_port_link_activity_leds,
    input wire logic        i_vmot_low,
    input wire logic        i_vmot_high,
    input wire logic        o_motor_led,
    input wire logic        o_step,
    input wire logic        o_manual_speed,
    input wire logic        o_busy,
    input wire logic [31:0] o_pos
);
    logic [2:0] rc_q;
    logic       live;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Outputs sit at zero just after reset, so value checks wait.
    always_ff @(posedge i_clk_sys or negedge i_nrst)
        if (!i_nrst) rc_q <= 3'h0;
        else if (rc_q != 3'h5) rc_q <= rc_q + 3'h1;
    assign live = (rc_q == 3'h5);
    sequence s_wr_ro;
        i_psel && i_penable && i_pwrite &&
        (i_paddr == `DCS_A_STAT || i_paddr == `DCS_A_POS);
    endsequence
    a_node_addr_sum: assert property (live |-> o_node_addr ==
        {3'h0, $past(i_addr_tens)} * 7'd10 + {3'h0, $past(i_addr_ones)})
        else $error("node address wrong");
    a_motor_led_ok: assert property (live |-> o_motor_led ==
        !($past(i_vmot_low) || $past(i_vmot_high)))
        else $error("motor led wrong");
    a_led_dark_unlinked: assert property (live && i_link == 2'h0 &&
        $past(i_link) == 2'h0 |-> o_port_link_activity_leds == 2'h0)
        else $error("port led lit without link");
    a_ro_write_refused: assert property (s_wr_ro |-> o_pslverr)
        else $error("read-only write accepted");
    a_run_has_cause: assert property ($rose(o_busy) |->
        $past(i_pd_valid || (i_psel && i_penable && i_pwrite)))
        else $error("run started without command");
    a_manual_in_run: assert property ($rose(o_manual_speed) |->
        $past(i_pd_valid || (i_psel && i_penable && i_pwrite)))
        else $error("manual run started without command");
    a_step_in_run: assert property (o_step |-> $past(o_busy))
        else $error("step while idle");
    a_pos_unit_step: assert property (live && o_pos != $past(o_pos)
        |-> o_pos - $past(o_pos) == 32'h1 || $past(o_pos) - o_pos == 32'h1)
        else $error("position jumped");
endmodule : dcs_props
bind dcs_top dcs_props u_props (.i_clk_sys, .i_nrst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .o_pslverr, .i_pd_valid, .i_addr_tens,
    .i_addr_ones, .o_node_addr, .i_link, .o_port_link_activity_leds,
    .i_vmot_low, .i_vmot_high, .o_motor_led, .o_step, .o_manual_speed,
    .o_busy, .o_pos);

// ==== sim/dcs_mn_model.sv ====
/* Managing node model: sends one process data frame per request.
   Assumes requests are raised by the bench just after a rising edge. */
`timescale 1ns/1ps
// ====================================================
// Model
module dcs_mn_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_send,
    input  wire logic [7:0]  i_word,
    input  wire logic [31:0] i_tgt,
    output logic             o_pd_valid = 1'b0,
    output logic [7:0]       o_pd_ctrl = 8'h00,
    output logic [31:0]      o_pd_target = 32'h0
);
    // Word and target travel together; between frames both lines flip
    // so a design that reads them outside a frame is caught.
    always @(posedge i_clk_sys)
    begin
        o_pd_valid <= i_send;
        o_pd_ctrl <= i_send ? i_word : ~o_pd_ctrl;
        o_pd_target <= i_send ? i_tgt : ~o_pd_target;
    end
endmodule : dcs_mn_model

// ==== sim/tb_drive_control_word_sequencer.sv ====
/* Testbench of the sequencer with a managing node model.
   Assumes the design files and the constants header on the path. */
`timescale 1ns/1ps
`include "dcs_consts.svh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin mismatches++; \
  $display("wrong value at %0t: %0h not %0h", $time, (g), (x)); end end
// ====================================================
// Bench
module tb_drive_control_word_sequencer
    import dcs_pkg::*;
;
    logic i_clk_sys = 0, i_nrst = 0, i_psel = 0, i_penable = 0;
    logic i_pwrite = 0, send = 0, i_vmot_low = 0, i_vmot_high = 0, e, pl;
    logic [7:0] i_paddr = 0, word = 0, i_pd_ctrl;
    logic [31:0] i_pwdata = 0, tgt = 0, r, o_prdata, i_pd_target, o_pos, v;
    logic signed [31:0] mn;
    logic [3:0] i_addr_tens = 0, i_addr_ones = 0, t, u;
    logic [1:0] i_link = 0, i_act = 0, o_port_link_activity_leds;
    logic [6:0] o_node_addr;
    logic o_pready, o_pslverr, i_pd_valid, o_motor_led, o_step, o_dir;
    logic o_manual_speed, o_busy;
    int mismatches = 0, n_checks = 0, cyc_n = 0, k, cnt;
    dcs_top #(.FLICK_DIV(8), .POS_DIV(2), .MAN_DIV(6)) DUT (.i_clk_sys,
        .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_pd_valid, .i_pd_ctrl,
        .i_pd_target, .i_addr_tens, .i_addr_ones, .o_node_addr, .i_link,
        .i_act, .o_port_link_activity_leds, .i_vmot_low, .i_vmot_high,
        .o_motor_led, .o_step, .o_dir, .o_manual_speed, .o_busy, .o_pos);
    dcs_mn_model u_mn (.i_clk_sys, .i_send(send), .i_word(word),
        .i_tgt(tgt), .o_pd_valid(i_pd_valid), .o_pd_ctrl(i_pd_ctrl),
        .o_pd_target(i_pd_target));
    // Clock and a hang guard well above the expected run length.
    always #25 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            mismatches++;
            test_done();
        end
    end
    task test_done;
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // One APB transfer; waits on pready, takes data at that edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1;
        i_penable <= 0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1;
        @(posedge i_clk_sys);
        // Only the hang guard ends a wait for the answer.
        while (o_pready !== 1'b1)
            @(posedge i_clk_sys);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask : apb
    task pd(input logic [7:0] w, input logic [31:0] tv);
        @(posedge i_clk_sys);
        send <= 1;
        word <= w;
        tgt <= tv;
        @(posedge i_clk_sys);
        send <= 0;
        repeat (3) @(posedge i_clk_sys);
    endtask : pd
    // Waits for the run to end and keeps the lowest position passed.
    task idle;
        mn = o_pos;
        while (o_busy !== 1'b0)
        begin
            @(posedge i_clk_sys);
            if ($signed(o_pos) < mn) mn = o_pos;
        end
    endtask : idle
    initial
    begin
        void'($urandom(21));
        repeat (6) @(posedge i_clk_sys);
        i_nrst <= 1;
        repeat (3) @(posedge i_clk_sys);
        apb(0, `DCS_A_TGT, 0);
        `CHK(r, 32'h0)
        apb(0, 8'h40, 0);
        `CHK(e, 1'b1)
        for (k = 0; k < 6; k++)
        begin
            t = (k == 0) ? 4'h0 : 4'($urandom % 10);
            u = (k == 0) ? 4'h0 : 4'($urandom % 10);
            i_addr_tens <= t;
            i_addr_ones <= u;
            repeat (3) @(posedge i_clk_sys);
            `CHK(o_node_addr, 7'(t * 10 + u))
            if (k == 0) apb(0, `DCS_A_STAT, 0);
            if (k == 0) `CHK(r[15], 1'b1)
        end
        for (k = 0; k < 4; k++)
        begin
            {i_vmot_high, i_vmot_low} <= 2'(k);
            repeat (3) @(posedge i_clk_sys);
            `CHK(o_motor_led, k == 0)
        end
        i_link <= 2'h3;
        repeat (20) @(posedge i_clk_sys);
        `CHK(o_port_link_activity_leds, 2'h3)
        cnt = 0;
        pl = 1;
        for (k = 0; k < 80; k++)
        begin
            @(posedge i_clk_sys);
            i_act <= {1'b0, k % 4 == 0};
            if (o_port_link_activity_leds[0] !== pl) cnt++;
            pl = o_port_link_activity_leds[0];
        end
        `CHK(cnt > 3, 1'b1)
        `CHK(o_port_link_activity_leds[1], 1'b1)
        i_link <= 0;
        i_act <= 0;
        repeat (3) @(posedge i_clk_sys);
        `CHK(o_port_link_activity_leds, 2'h0)
        pd(8'h14, 7);
        `CHK(o_busy, 1'b0)
        apb(1, `DCS_A_CYC, 2);
        apb(1, `DCS_A_TGT, 32'h7fff_fffb);
        apb(0, `DCS_A_TGT, 0);
        `CHK(r, 32'hffff_fffb)
        apb(1, `DCS_A_TGT, 12);
        apb(0, `DCS_A_STAT, 0);
        `CHK({r[3], o_busy}, 2'b10)
        apb(1, `DCS_A_CTRL, 32'h10);
        repeat (2) @(posedge i_clk_sys);
        `CHK(o_busy, 1'b1)
        idle();
        `CHK(o_pos, 32'd12)
        `CHK(o_dir, 1'b1)
        for (k = 0; k < 2; k++)
        begin
            apb(1, `DCS_A_CTRL, k ? 32'h12 : 32'h11);
            repeat (2) @(posedge i_clk_sys);
            `CHK(o_manual_speed, 1'b1)
            apb(1, `DCS_A_CTRL, k ? 32'h0 : 32'h10);
            repeat (2) @(posedge i_clk_sys);
            `CHK(o_busy, 1'b0)
        end
        apb(1, `DCS_A_CYC, 5);
        apb(1, `DCS_A_CTRL, 32'h11);
        `CHK({e, o_busy}, 2'b10)
        v = 20 + $urandom % 10;
        pd(8'h14, v);
        `CHK(o_busy, 1'b1)
        pd(8'h14, v + 8);
        idle();
        `CHK(o_pos, v + 8)
        pd(8'h14, 0);
        pd(8'h11, 0);
        `CHK(o_manual_speed, 1'b1)
        pd(8'h14, 40);
        `CHK({o_manual_speed, o_busy}, 2'b01)
        apb(0, `DCS_A_CTRL, 0);
        `CHK(r[1:0], 2'h0)
        idle();
        `CHK(o_pos, 32'd40)
        pd(8'h14, 0);
        pd(8'h00, 0);
        `CHK(o_busy, 1'b0)
        apb(1, `DCS_A_CYC, 2);
        apb(1, `DCS_A_TGT, 3);
        apb(1, `DCS_A_CYC, 5);
        pd(8'h10, 32'($urandom % 100));
        `CHK(o_busy, 1'b1)
        idle();
        `CHK(o_pos, 32'd3)
        apb(1, `DCS_A_CYC, 2);
        // A target written during a manual run drops the manual bits.
        apb(1, `DCS_A_CTRL, 32'h11);
        apb(1, `DCS_A_TGT, 5);
        apb(0, `DCS_A_CTRL, 0);
        `CHK(r, 32'h10)
        idle();
        `CHK(o_pos, 32'd5)
        apb(1, `DCS_A_LOOP, 2);
        apb(1, `DCS_A_CTRL, 0);
        apb(1, `DCS_A_TGT, 1);
        apb(1, `DCS_A_CTRL, 32'h10);
        // The run shows on o_busy only after the write edge has passed.
        repeat (2) @(posedge i_clk_sys);
        idle();
        `CHK(mn, 32'hffff_ffff)
        `CHK(o_pos, 32'd1)
        `CHK(o_dir, 1'b1)
        test_done();
    end
endmodule : tb_drive_control_word_sequencer
